// >>> logic/crsm_pkg.sv
// Purpose: Constants for the core reset and supply monitor.
// Assumes: 250 MHz clock.
// Notes: Times are in ns; cycle counts derive from them.
package crsm_pkg;
    // ======================================================
    // Timing
    localparam int CLK_NS = 4;
    localparam int POR_MIN_LOW_NS = 361;
    localparam int POR_MIN_LOW_CYC = (POR_MIN_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int POR_ASSERT_MAX_NS = 1500;
    localparam int POR_ASSERT_MAX_CYC = POR_ASSERT_MAX_NS / CLK_NS;
    localparam int OV_SWITCH_MAX_NS = 1000;
    localparam int OV_SWITCH_MAX_CYC = OV_SWITCH_MAX_NS / CLK_NS;
    localparam int UV_FILTER_MIN_NS = 800;
    localparam int UV_FILTER_MAX_NS = 2000;
    localparam int UV_FILTER_CYC = (UV_FILTER_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int BG_FILTER_NS = 9000;
    localparam int BG_FILTER_CYC = BG_FILTER_NS / CLK_NS;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] POR_MIN_LOW_LEN = CNT_W'(POR_MIN_LOW_CYC);
    localparam logic [CNT_W-1:0] UV_FILTER_LEN = CNT_W'(UV_FILTER_CYC);
    localparam logic [CNT_W-1:0] BG_FILTER_LEN = CNT_W'(BG_FILTER_CYC);
    localparam logic [CNT_W-1:0] BG_DROP_LEN = 12'h001;
    localparam logic [3:0] SOFT_RESET_LEN = 4'h8;
    // ======================================================
    // Serial words and register map
    localparam int WORD_W = 16;
    localparam int ADDR_W = 10;
    localparam int CMD_WRITE_BIT = 15;
    localparam logic [ADDR_W-1:0] ADDR_DRIVER_CONFIGURATION = 10'h1C5;
    localparam logic [ADDR_W-1:0] ADDR_DRIVER_FAULT_FLAGS = 10'h1D2;
    localparam logic [ADDR_W-1:0] ADDR_PART_IDENTIFICATION = 10'h1D5;
    localparam logic [ADDR_W-1:0] ADDR_SERIAL_SOFT_RESET = 10'h1FF;
    localparam int CFG_UV5_IRQ_EN = 0;
    localparam int CFG_GATE_IRQ_EN = 1;
    localparam int CFG_GATE_EXT_EN = 2;
    localparam logic [WORD_W-1:0] CFG_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] CFG_WRITE_MASK = 16'h0007;
    localparam int FLG_UV5 = 0;
    localparam int FLG_GATE_UV = 1;
    localparam int FLG_UV5_LIVE = 2;
    localparam int FLG_GATE_UV_LIVE = 3;
    localparam int FLG_OV5_LIVE = 4;
    localparam logic [WORD_W-1:0] CONTROL_PATTERN = 16'h00A8;
    localparam logic [WORD_W-1:0] READ_IN_RESET = 16'h0000;
    // Identification value is arbitrary.
    localparam logic [WORD_W-1:0] PART_ID_VALUE = 16'h5C3A;
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_CMD = 3'b010,
        PH_DATA = 3'b100
    } crsm_phase_t;
endpackage : crsm_pkg

// >>> logic/crsm_word_if.sv
`timescale 1ns/100ps
// Purpose: Word transport between serial shifter and core.
// Assumes: One clock domain.
// Notes: word_valid is a one-cycle pulse.
interface crsm_word_if;
    logic enable;
    logic frame_active;
    logic word_valid;
    logic [15:0] word;
    logic [15:0] tx_word;
    modport shifter(input enable, input tx_word, output frame_active, output word_valid,
                    output word);
    modport core(output enable, output tx_word, input frame_active, input word_valid,
                 input word);
endinterface : crsm_word_if

// >>> logic/crsm_deglitch.sv
`timescale 1ns/100ps
// Purpose: Anti-glitch filter with separate rise and fall lengths.
// Assumes: Input synchronous to clk_i.
// Notes: Output follows input once it has held for the length.
module crsm_deglitch #(
    parameter logic [11:0] RISE_LEN = 12'h001,
    parameter logic [11:0] FALL_LEN = 12'h001
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic in_i,
    output logic out_o
);
    logic [11:0] cnt;
    logic [11:0] limit;
    assign limit = in_i ? RISE_LEN : FALL_LEN;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt <= 12'h000;
            out_o <= 1'b0;
        end else if (in_i == out_o) begin
            cnt <= 12'h000;
        end else if (cnt >= limit - 12'h001) begin
            cnt <= 12'h000;
            out_o <= in_i;
        end else begin
            cnt <= cnt + 12'h001;
        end
    end
endmodule : crsm_deglitch

// >>> logic/crsm_spi_shift.sv
`timescale 1ns/100ps
// Purpose: Serial shifter, 16-bit words, sample on rising SCLK.
// Assumes: SCLK phases last at least three clk_i cycles.
// Notes: Held silent while the core enable is low.
module crsm_spi_shift (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    crsm_word_if.shifter bus
);
    logic sclk_q;
    logic rise;
    logic fall;
    logic [3:0] bit_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    assign rise = sclk_i & ~sclk_q;
    assign fall = ~sclk_i & sclk_q;
    assign miso_o = tx[15];
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk_i;
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bit_cnt <= 4'h0;
            rx <= 16'h0000;
            bus.word_valid <= 1'b0;
            bus.word <= 16'h0000;
            bus.frame_active <= 1'b0;
        end else if (!bus.enable || cs_n_i) begin
            bit_cnt <= 4'h0;
            rx <= 16'h0000;
            bus.word_valid <= 1'b0;
            bus.frame_active <= 1'b0;
        end else begin
            bus.frame_active <= 1'b1;
            bus.word_valid <= rise && (bit_cnt == 4'hF);
            if (rise) begin
                rx <= {rx[14:0], mosi_i};
                bit_cnt <= bit_cnt + 4'h1;
                bus.word <= {rx[14:0], mosi_i};
            end
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx <= 16'h0000;
        end else if (!bus.enable) begin
            tx <= 16'h0000;
        end else if (cs_n_i || (fall && bit_cnt == 4'h0)) begin
            tx <= bus.tx_word;
        end else if (fall) begin
            tx <= {tx[14:0], 1'b0};
        end
    end
    AST_SHIFT_SILENT: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !bus.enable |=> !miso_o && !bus.word_valid)
        else $error("Serial port active during core reset.");
endmodule : crsm_spi_shift

// >>> logic/crsm_top.sv
`timescale 1ns/100ps
// Purpose: Core reset generation and 5 V supply monitoring.
// Assumes: Comparator inputs are synchronous to clk_i.
// Notes: Registers and serial logic clear on core reset; filters, core regulator and 5 V disconnect do not.
module crsm_top (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic external_reset_pin_n_i,
    input wire logic core_supply_low_i,
    input wire logic core_supply_high_i,
    input wire logic bandgap_stable_i,
    input wire logic five_volt_ov_i,
    input wire logic five_volt_ov_gate_i,
    input wire logic five_volt_uv_raw_i,
    input wire logic gate_supply_undervoltage_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic core_reset_n_o,
    output logic bandgap_ready_o,
    output logic core_regulator_enable_o,
    output logic gate_regulator_enable_o,
    output logic five_volt_disconnect_o,
    output logic predriver_disable_o,
    output logic irq_n_o
);
    import crsm_pkg::*;

    localparam int POR_WAIT = POR_ASSERT_MAX_CYC;
    localparam int OV_WAIT = OV_SWITCH_MAX_CYC;

    crsm_word_if spi ();

    logic bandgap_ready;
    logic five_volt_undervoltage;
    logic power_on_reset_n;
    logic serial_soft_reset_n;
    logic [11:0] low_cnt;
    logic [3:0] soft_cnt;
    logic soft_req;
    logic [WORD_W-1:0] driver_configuration;
    logic [WORD_W-1:0] sticky_flags;
    logic [WORD_W-1:0] flags_view;
    crsm_phase_t phase;
    logic cmd_write;
    logic [ADDR_W-1:0] cmd_addr;
    logic cmd_take;
    logic data_take;
    logic flags_read;
    logic [ADDR_W-1:0] word_addr;

    // ======================================================
    // Reference and filters
    crsm_deglitch #(
        .RISE_LEN(BG_FILTER_LEN),
        .FALL_LEN(BG_DROP_LEN)
    ) u_bg_filter (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_i(bandgap_stable_i),
        .out_o(bandgap_ready)
    );

    crsm_deglitch #(
        .RISE_LEN(UV_FILTER_LEN),
        .FALL_LEN(UV_FILTER_LEN)
    ) u_uv_filter (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_i(five_volt_uv_raw_i),
        .out_o(five_volt_undervoltage)
    );

    assign bandgap_ready_o = bandgap_ready;

    // ======================================================
    // Power-on reset
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_cnt <= 12'h000;
        end else if (!core_supply_low_i) begin
            low_cnt <= 12'h000;
        end else if (low_cnt < POR_MIN_LOW_LEN) begin
            low_cnt <= low_cnt + 12'h001;
        end
    end

    // The regulator cannot bring the supply up before the reference is
    // ready, so reset is held regardless of the comparators until then.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            power_on_reset_n <= 1'b0;
        end else if (!bandgap_ready) begin
            power_on_reset_n <= 1'b0;
        end else if (low_cnt >= POR_MIN_LOW_LEN - 12'h001 && core_supply_low_i) begin
            power_on_reset_n <= 1'b0;
        end else if (core_supply_high_i) begin
            power_on_reset_n <= 1'b1;
        end
    end

    // ======================================================
    // Serial soft reset
    // The stretch counter is reset by resetn_i only, so the pulse
    // survives the core reset that it causes.
    assign soft_req = data_take && cmd_write && cmd_addr == ADDR_SERIAL_SOFT_RESET;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            soft_cnt <= 4'h0;
        end else if (soft_req) begin
            soft_cnt <= SOFT_RESET_LEN;
        end else if (soft_cnt != 4'h0) begin
            soft_cnt <= soft_cnt - 4'h1;
        end
    end

    assign serial_soft_reset_n = (soft_cnt == 4'h0);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            core_reset_n_o <= 1'b0;
        end else begin
            // Gate supply and battery play no part here.
            core_reset_n_o <= power_on_reset_n
                && external_reset_pin_n_i
                && serial_soft_reset_n;
        end
    end

    // ======================================================
    // Regulators and supply protection
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            core_regulator_enable_o <= 1'b0;
            gate_regulator_enable_o <= 1'b0;
            five_volt_disconnect_o <= 1'b0;
        end else begin
            core_regulator_enable_o <= bandgap_ready;
            gate_regulator_enable_o <= bandgap_ready
                && !five_volt_ov_gate_i
                && core_reset_n_o
                && !driver_configuration[CFG_GATE_EXT_EN];
            five_volt_disconnect_o <= five_volt_ov_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            predriver_disable_o <= 1'b1;
        end else begin
            predriver_disable_o <= five_volt_undervoltage
                || gate_supply_undervoltage_i
                || !core_reset_n_o;
        end
    end

    // ======================================================
    // Serial command handling
    assign spi.enable = core_reset_n_o;
    assign word_addr = spi.word[ADDR_W-1:0];
    assign cmd_take = spi.word_valid && phase == PH_CMD;
    assign data_take = spi.word_valid && phase == PH_DATA;
    assign flags_read = cmd_take && !spi.word[CMD_WRITE_BIT]
        && word_addr == ADDR_DRIVER_FAULT_FLAGS;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase <= PH_IDLE;
        end else if (!core_reset_n_o || !spi.frame_active) begin
            phase <= PH_IDLE;
        end else begin
            unique case (phase)
                PH_IDLE: begin
                    phase <= PH_CMD;
                end
                PH_CMD: begin
                    if (spi.word_valid) begin
                        phase <= PH_DATA;
                    end
                end
                PH_DATA: begin
                    if (spi.word_valid) begin
                        phase <= PH_CMD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_write <= 1'b0;
            cmd_addr <= '0;
        end else if (!core_reset_n_o) begin
            cmd_write <= 1'b0;
            cmd_addr <= '0;
        end else if (cmd_take) begin
            cmd_write <= spi.word[CMD_WRITE_BIT];
            cmd_addr <= word_addr;
        end
    end

    function automatic logic [WORD_W-1:0] read_reg(input logic [ADDR_W-1:0] a);
        logic [WORD_W-1:0] v;
        v = '0;
        if (a == ADDR_DRIVER_CONFIGURATION) begin
            v = driver_configuration;
        end else if (a == ADDR_DRIVER_FAULT_FLAGS) begin
            v = flags_view;
        end else if (a == ADDR_PART_IDENTIFICATION) begin
            v = PART_ID_VALUE;
        end
        return v;
    endfunction : read_reg

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            spi.tx_word <= READ_IN_RESET;
        end else if (!core_reset_n_o) begin
            spi.tx_word <= READ_IN_RESET;
        end else if (!spi.frame_active) begin
            spi.tx_word <= CONTROL_PATTERN;
        end else if (cmd_take) begin
            spi.tx_word <= spi.word[CMD_WRITE_BIT] ? '0 : read_reg(word_addr);
        end else if (data_take) begin
            spi.tx_word <= CONTROL_PATTERN;
        end
    end

    crsm_spi_shift u_shift (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .sclk_i(spi_sclk_i),
        .cs_n_i(spi_cs_n_i),
        .mosi_i(spi_mosi_i),
        .miso_o(spi_miso_o),
        .bus(spi.shifter)
    );

    // ======================================================
    // Registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            driver_configuration <= CFG_RESET;
        end else if (!core_reset_n_o) begin
            driver_configuration <= CFG_RESET;
        end else if (data_take && cmd_write
                     && cmd_addr == ADDR_DRIVER_CONFIGURATION) begin
            driver_configuration <= spi.word & CFG_WRITE_MASK;
        end
    end

    // A set in the same cycle as the read wins, so no event is lost.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sticky_flags <= '0;
        end else if (!core_reset_n_o) begin
            sticky_flags <= '0;
        end else begin
            sticky_flags[FLG_UV5] <= five_volt_undervoltage
                || (sticky_flags[FLG_UV5] && !flags_read);
            sticky_flags[FLG_GATE_UV] <= gate_supply_undervoltage_i
                || (sticky_flags[FLG_GATE_UV] && !flags_read);
        end
    end

    always_comb begin
        flags_view = sticky_flags;
        flags_view[FLG_UV5_LIVE] = five_volt_undervoltage;
        flags_view[FLG_GATE_UV_LIVE] = gate_supply_undervoltage_i;
        flags_view[FLG_OV5_LIVE] = five_volt_ov_i;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_n_o <= 1'b1;
        end else begin
            irq_n_o <= !((driver_configuration[CFG_UV5_IRQ_EN] && sticky_flags[FLG_UV5])
                || (driver_configuration[CFG_GATE_IRQ_EN]
                    && sticky_flags[FLG_GATE_UV]));
        end
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    AST_CORE_RESET_AND: assert property (
        !external_reset_pin_n_i || !serial_soft_reset_n |=> !core_reset_n_o)
        else $error("Core reset missed a reset source.");

    AST_PATTERN_IDLE: assert property (
        core_reset_n_o && !spi.frame_active ##1 core_reset_n_o
        |=> spi.tx_word == CONTROL_PATTERN)
        else $error("Control pattern not loaded between frames.");

    AST_READ_ZERO: assert property (
        !core_reset_n_o |=> spi.tx_word == READ_IN_RESET)
        else $error("Nonzero read data during reset.");

    AST_POR_NEEDS_BG: assert property (
        !bandgap_ready |=> !power_on_reset_n ##1 !core_reset_n_o)
        else $error("Core left reset without a ready reference.");

    AST_POR_ASSERT_TIME: assert property (
        $rose(core_supply_low_i) && bandgap_ready
        ##1 (core_supply_low_i && bandgap_ready)[*8]
        |-> ##[1:POR_WAIT] !power_on_reset_n || !core_supply_low_i)
        else $error("Power-on reset late after undervoltage.");

    AST_POR_MIN_LOW: assert property (
        $fell(power_on_reset_n) |-> $past(!bandgap_ready) || $past(low_cnt) >= 12'h05A)
        else $error("Power-on reset on a short dip.");

    AST_POR_HYST: assert property (
        $rose(power_on_reset_n) |-> $past(core_supply_high_i) && $past(bandgap_ready))
        else $error("Power-on reset released below upper threshold.");

    AST_CORE_REG_BG: assert property (
        core_regulator_enable_o |-> $past(bandgap_ready))
        else $error("Core regulator started before reference ready.");

    AST_OV_DISCONNECT: assert property (
        five_volt_ov_i |-> ##[1:OV_WAIT] five_volt_disconnect_o)
        else $error("Overvoltage disconnect late.");

    AST_OV_GATE_REG: assert property (
        five_volt_ov_gate_i |=> !gate_regulator_enable_o)
        else $error("Gate regulator on during overvoltage.");

    AST_PREDRV_OFF: assert property (
        five_volt_undervoltage || gate_supply_undervoltage_i |=> predriver_disable_o)
        else $error("Pre-drivers on during undervoltage.");

    AST_UV_FILTER: assert property (
        !five_volt_undervoltage && $rose(five_volt_uv_raw_i)
        |=> !five_volt_undervoltage [*8])
        else $error("Undervoltage passed the filter too early.");

    AST_UV_FLAG_IRQ: assert property (
        $rose(five_volt_undervoltage) && core_reset_n_o
        && driver_configuration[CFG_UV5_IRQ_EN] && !flags_read
        |=> sticky_flags[FLG_UV5] ##1 !irq_n_o)
        else $error("Undervoltage flag or interrupt missing.");

    AST_FLAG_STICKY: assert property (
        sticky_flags[FLG_UV5] && core_reset_n_o && !flags_read ##1 core_reset_n_o
        |-> sticky_flags[FLG_UV5])
        else $error("Undervoltage flag lost before read.");
endmodule : crsm_top

// >>> dv/crsm_host_model.sv
// Purpose: Host microcontroller model on the serial port.
// Assumes: Serial clock phases of 4 clk_i cycles, mode 0, MSB first.
// Notes: MOSI flips when deselected so stale data never looks valid.
`timescale 1ns/100ps
module crsm_host_model (
    input wire logic clk_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // ======================================================
    // Word transfer
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        for (int i = 15; i >= 0; i--) begin
            mosi_o = tx[i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            rx[i] = miso_i;
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
        end
    endtask : xfer
    // Command word then data word, returning the pattern and the data seen.
    task automatic frame(input logic [15:0] cmd, input logic [15:0] dat,
                         output logic [15:0] pat, output logic [15:0] rd);
        // The core needs a few cycles after reset release to load the pattern.
        repeat (3) @(negedge clk_i);
        cs_n_o = 1'b0;
        xfer(cmd, pat);
        xfer(dat, rd);
        repeat (2) @(negedge clk_i);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (4) @(negedge clk_i);
    endtask : frame
endmodule : crsm_host_model

// >>> dv/test_crsm_top.sv
// Purpose: Self-checking bench for the core reset and supply monitor.
// Assumes: Comparators are driven directly at the falling clock edge.
// Notes: Filter delays are judged against their minimum and maximum times.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
`define WAITF(c, n) begin wcnt = 0; while (!(c) && wcnt < (n)) begin @(negedge clk_i); \
    wcnt++; end if (!(c)) begin n_mismatch++; finish_test(); end end
module test_crsm_top;
    import crsm_pkg::*;
    logic clk_i = 1'b0, resetn_i = 1'b0, ext_n = 1'b1, sup_lo = 1'b0, sup_hi = 1'b0;
    logic bg_st = 1'b0, ov = 1'b0, ov_g = 1'b0, uv = 1'b0, g_uv = 1'b0;
    logic sclk, cs_n, mosi, miso, core_n, bg_rdy, creg, greg, disc, pdis, irq_n;
    logic [15:0] pat, rd;
    int n_mismatch = 0, checks_done = 0, wcnt;
    always #2 clk_i = ~clk_i;
    crsm_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .external_reset_pin_n_i(ext_n),
        .core_supply_low_i(sup_lo), .core_supply_high_i(sup_hi), .bandgap_stable_i(bg_st),
        .five_volt_ov_i(ov), .five_volt_ov_gate_i(ov_g), .five_volt_uv_raw_i(uv),
        .gate_supply_undervoltage_i(g_uv), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .core_reset_n_o(core_n),
        .bandgap_ready_o(bg_rdy), .core_regulator_enable_o(creg),
        .gate_regulator_enable_o(greg), .five_volt_disconnect_o(disc),
        .predriver_disable_o(pdis), .irq_n_o(irq_n));
    crsm_host_model host (.clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n),
        .mosi_o(mosi));
    // ======================================================
    // Access tasks
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic rd_chk(input logic [9:0] a, input logic [15:0] ep, input logic [15:0] ex);
        host.frame({6'h00, a}, 16'h0000, pat, rd);
        `CHK("pattern", ep, pat)
        `CHK("read data", ex, rd)
    endtask : rd_chk
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        host.frame({6'h20, a}, d, pat, rd);
    endtask : wr
    // ======================================================
    // Sequence
    initial begin
        repeat (5) @(negedge clk_i);
        `CHK("core reset", 1'b0, core_n)
        `CHK("predriver off", 1'b1, pdis)
        resetn_i = 1'b1;
        rd_chk(ADDR_PART_IDENTIFICATION, 16'h0000, READ_IN_RESET);
        bg_st = 1'b1;
        `CHK("regulator early", 1'b0, creg)
        `WAITF(bg_rdy, 2400)
        `CHK("reference filter", 1'b1, wcnt >= 2240)
        repeat (10) @(negedge clk_i);
        `CHK("regulator on", 1'b1, creg)
        `CHK("held in reset", 1'b0, core_n)
        sup_hi = 1'b1;
        `WAITF(core_n, 10)
        g_uv = 1'b1;
        rd_chk(ADDR_PART_IDENTIFICATION, CONTROL_PATTERN, PART_ID_VALUE);
        `CHK("gate uv off", 1'b1, pdis)
        g_uv = 1'b0;
        repeat (3) @(negedge clk_i);
        `CHK("predriver on", 1'b0, pdis)
        rd_chk(ADDR_DRIVER_FAULT_FLAGS, CONTROL_PATTERN, 16'h0002);
        rd_chk(10'h100, CONTROL_PATTERN, 16'h0000);
        wr(ADDR_DRIVER_CONFIGURATION, 16'h0001);
        rd_chk(ADDR_DRIVER_CONFIGURATION, CONTROL_PATTERN, 16'h0001);
        // A glitch shorter than the filter must not reach the pre-drivers.
        uv = 1'b1;
        repeat (150) @(negedge clk_i);
        uv = 1'b0;
        `CHK("glitch", 1'b0, pdis)
        repeat (300) @(negedge clk_i);
        uv = 1'b1;
        `WAITF(pdis, 600)
        `CHK("uv filter", 1'b1, wcnt >= 200 && wcnt <= 500)
        repeat (3) @(negedge clk_i);
        `CHK("irq", 1'b0, irq_n)
        uv = 1'b0;
        `WAITF(!pdis, 600)
        rd_chk(ADDR_DRIVER_FAULT_FLAGS, CONTROL_PATTERN, 16'h0001);
        rd_chk(ADDR_DRIVER_FAULT_FLAGS, CONTROL_PATTERN, 16'h0000);
        `CHK("gate regulator", 1'b1, greg)
        ov = 1'b1;
        `WAITF(disc, 250)
        repeat (20) @(negedge clk_i);
        `CHK("disconnect held", 1'b1, disc)
        ov = 1'b0;
        `WAITF(!disc, 10)
        ov_g = 1'b1;
        `WAITF(!greg, 10)
        ov_g = 1'b0;
        `WAITF(greg, 10)
        ext_n = 1'b0;
        `WAITF(!core_n, 5)
        rd_chk(ADDR_DRIVER_CONFIGURATION, 16'h0000, READ_IN_RESET);
        ext_n = 1'b1;
        `WAITF(core_n, 10)
        rd_chk(ADDR_DRIVER_CONFIGURATION, CONTROL_PATTERN, CFG_RESET);
        wr(ADDR_DRIVER_CONFIGURATION, 16'h0007);
        g_uv = 1'b1;
        repeat (3) @(negedge clk_i);
        `CHK("gate irq", 1'b0, irq_n)
        `CHK("gate regulator external", 1'b0, greg)
        g_uv = 1'b0;
        wr(ADDR_SERIAL_SOFT_RESET, 16'h0000);
        `WAITF(core_n, 20)
        `CHK("irq after soft reset", 1'b1, irq_n)
        rd_chk(ADDR_DRIVER_CONFIGURATION, CONTROL_PATTERN, CFG_RESET);
        sup_lo = 1'b1;
        repeat (60) @(negedge clk_i);
        sup_lo = 1'b0;
        `CHK("short dip", 1'b1, core_n)
        repeat (5) @(negedge clk_i);
        sup_lo = 1'b1;
        `WAITF(!core_n, 470)
        `CHK("dip length", 1'b1, wcnt >= POR_MIN_LOW_CYC && wcnt <= POR_ASSERT_MAX_CYC)
        sup_lo = 1'b0;
        sup_hi = 1'b0;
        repeat (20) @(negedge clk_i);
        `CHK("hysteresis", 1'b0, core_n)
        sup_hi = 1'b1;
        `WAITF(core_n, 10)
        finish_test();
    end
endmodule : test_crsm_top
